// ---- include/wst_pkg.sv ----
// constants of the windowed supervision timer
package wst_pkg;
  // register byte offsets
  localparam logic [4:0] WST_OFF_MODE = 5'h00;
  localparam logic [4:0] WST_OFF_TIMEOUT = 5'h04;
  localparam logic [4:0] WST_OFF_FEED = 5'h08;
  localparam logic [4:0] WST_OFF_VALUE = 5'h0c;
  localparam logic [4:0] WST_OFF_WINDOW = 5'h10;
  localparam logic [4:0] WST_OFF_WARN = 5'h14;
  localparam logic [4:0] WST_OFF_STATUS = 5'h18;
  localparam logic [4:0] WST_OFF_MASK = 5'h1c;
  // mode register bit positions
  localparam int WST_MODE_EN = 0;
  localparam int WST_MODE_RST_EN = 1;
  localparam int WST_MODE_WIN_EN = 2;
  localparam int WST_MODE_FLAG = 3;
  // status and mask bit positions
  localparam int WST_ST_TIMEOUT = 0;
  localparam int WST_ST_WARN = 1;
  localparam int WST_ST_FAULT = 2;
  // counter geometry and reset values
  localparam int WST_CNT_W = 24;
  localparam int WST_EV_W = 3;
  localparam logic [23:0] WST_TC_MIN = 24'h0000ff;
  localparam logic [23:0] WST_TC_RESET = 24'h0000ff;
  localparam logic [23:0] WST_WINDOW_RESET = 24'hffffff;
  localparam logic [23:0] WST_WARN_RESET = 24'h000000;
  localparam logic [2:0] WST_MASK_RESET = 3'h0;
  // divide-by-four prescaler
  localparam logic [1:0] WST_PRE_LAST = 2'h3;
  // feed sequence codes
  localparam logic [7:0] WST_FEED_FIRST = 8'haa;
  localparam logic [7:0] WST_FEED_SECOND = 8'h55;
endpackage

// ---- src/wst_tick_sync.sv ----
// synchroniser and edge detector for the supervision tick clock
`timescale 1ns/100ps
module wst_tick_sync
  import wst_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic tick_in,
  output logic tick
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } wst_sync_t;

  wst_sync_t st;
  wst_sync_t next_st;

  // shift the pin through two stages, third stage for the edge
  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.s1 = tick_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // one-cycle pulse per rising tick edge
  assign tick = ce & st.s2 & ~st.s3;
endmodule

// ---- src/wst_timer.sv ----
// windowed supervision timer: counter, feed checker, registers
//
// Function
// R1: counter running out before reload resets the chip.
// R2: windowed mode faults a reload arriving before the window opens.
// R3: warning interrupt when counter reaches the programmed warning value.
// R4: enable is set-only; cleared by reset or a watchdog event.
// R5: wrong feed sequence gives chip reset, or interrupt when reset disabled.
// R6: a flag records watchdog reset and survives that reset.
// R7: 24-bit counter behind divide-by-four prescaler, time-out 256 to 2^24.
// R8: tick clock from its own oscillator, synchronised before use.
// R9: valid reload loads the time-out value and clears warning state.
// R10: software programs values before enabling; enable cannot be withdrawn.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module wst_timer
  import wst_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic power_on_reset,
  input wire logic ce,
  input wire logic supervision_tick_clock,
  input wire logic [4:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic chip_reset_req,
  output logic irq
);
  typedef struct packed {
    logic en;
    logic rst_en;
    logic win_en;
    logic [23:0] timeout;
    logic [23:0] window;
    logic [23:0] warn;
    logic [23:0] cnt;
    logic [1:0] pre;
    logic armed;
    logic warned;
    logic [2:0] status;
    logic [2:0] mask;
    logic irq;
    logic chip_rst;
    logic [31:0] rdata;
  } wst_state_t;

  wst_state_t st;
  wst_state_t next_st;
  logic flag;
  logic next_flag;
  logic tick;

  // clamp a time-out value to the shortest legal period
  function automatic logic [23:0] wst_clamp(input logic [23:0] v);
    return (v < WST_TC_MIN) ? WST_TC_MIN : v;
  endfunction

  // tick clock crossing into the bus clock domain
  wst_tick_sync u_sync (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .tick_in(supervision_tick_clock),
    .tick(tick)
  ); // [R8]

  // event terms
  logic wr_ok;
  logic rd_ok;
  logic pre_tick;
  logic feed_wr;
  logic good_first;
  logic good_second;
  logic bad_feed;
  logic early;
  logic reload;
  logic fault;
  logic timeout_ev;
  logic warn_ev;
  logic reset_ev;
  logic [2:0] ev;
  logic [2:0] w1c;

  always_comb begin
    wr_ok = ce & wr;
    rd_ok = ce & rd;
    pre_tick = tick & st.en & (st.pre == WST_PRE_LAST); // [R7]
    feed_wr = wr_ok & (addr == WST_OFF_FEED);
    good_first = feed_wr & (wdata[7:0] == WST_FEED_FIRST);
    good_second = feed_wr & st.armed & (wdata[7:0] == WST_FEED_SECOND);
    bad_feed = st.en & feed_wr & ~good_first & ~good_second; // [R5]
    early = st.en & good_second & st.win_en & (st.cnt > st.window); // [R2]
    reload = st.en & good_second & ~early;
    fault = bad_feed | early;
    timeout_ev = pre_tick & (st.cnt == '0) & ~reload; // [R1]
    warn_ev = pre_tick & (st.cnt == st.warn) & ~st.warned & ~reload; // [R3]
    reset_ev = (timeout_ev | fault) & st.rst_en;
    ev = '0;
    ev[WST_ST_TIMEOUT] = timeout_ev & ~st.rst_en;
    ev[WST_ST_WARN] = warn_ev;
    ev[WST_ST_FAULT] = fault & ~st.rst_en; // [R5]
    w1c = '0;
    if (wr_ok && addr == WST_OFF_STATUS) begin
      w1c = wdata[2:0];
    end
  end

  // next state
  always_comb begin
    next_st = st;
    if (ce) begin
      // register writes
      if (wr_ok && addr == WST_OFF_MODE) begin
        if (!st.en) begin
          next_st.rst_en = wdata[WST_MODE_RST_EN];
          next_st.win_en = wdata[WST_MODE_WIN_EN];
        end
        if (wdata[WST_MODE_EN] && !st.en) begin
          next_st.en = 1'b1; // set-only from software [R4]
          next_st.cnt = st.timeout;
          next_st.pre = '0;
          next_st.warned = 1'b0;
        end
      end else if (wr_ok && addr == WST_OFF_TIMEOUT) begin
        next_st.timeout = wst_clamp(wdata[23:0]); // [R7]
      end else if (wr_ok && addr == WST_OFF_WINDOW) begin
        next_st.window = wdata[23:0];
      end else if (wr_ok && addr == WST_OFF_WARN) begin
        next_st.warn = wdata[23:0];
      end else if (wr_ok && addr == WST_OFF_MASK) begin
        next_st.mask = wdata[2:0];
      end
      // feed sequence tracking
      if (feed_wr) begin
        next_st.armed = good_first;
      end
      // prescaler and counter
      if (tick && st.en) begin
        next_st.pre = st.pre + 2'h1; // [R7]
      end
      if (pre_tick && st.cnt != '0) begin
        next_st.cnt = st.cnt - 24'h000001; // [R7]
      end
      if (warn_ev) begin
        next_st.warned = 1'b1;
      end
      if (reload) begin
        next_st.cnt = st.timeout; // [R9]
        next_st.pre = '0;
        next_st.warned = 1'b0; // [R9]
      end
      // watchdog events end supervision
      if (timeout_ev || fault) begin
        next_st.en = 1'b0; // [R4]
        next_st.armed = 1'b0;
      end
      next_st.chip_rst = reset_ev; // [R1] [R5]
      // status: set wins over clear
      next_st.status = (st.status & ~w1c) | ev;
      next_st.irq = |(next_st.status & next_st.mask);
      // read data, valid in the cycle after the strobe only
      next_st.rdata = '0;
      if (rd_ok) begin
        if (addr == WST_OFF_MODE) begin
          next_st.rdata[WST_MODE_EN] = st.en;
          next_st.rdata[WST_MODE_RST_EN] = st.rst_en;
          next_st.rdata[WST_MODE_WIN_EN] = st.win_en;
          next_st.rdata[WST_MODE_FLAG] = flag; // [R6]
        end else if (addr == WST_OFF_TIMEOUT) begin
          next_st.rdata[23:0] = st.timeout;
        end else if (addr == WST_OFF_VALUE) begin
          next_st.rdata[23:0] = st.cnt;
        end else if (addr == WST_OFF_WINDOW) begin
          next_st.rdata[23:0] = st.window;
        end else if (addr == WST_OFF_WARN) begin
          next_st.rdata[23:0] = st.warn;
        end else if (addr == WST_OFF_STATUS) begin
          next_st.rdata[2:0] = st.status;
        end else if (addr == WST_OFF_MASK) begin
          next_st.rdata[2:0] = st.mask;
        end
      end
    end
  end

  // reset flag: set wins over write-one clear
  always_comb begin
    next_flag = flag;
    if (ce) begin
      if (wr_ok && addr == WST_OFF_MODE && wdata[WST_MODE_FLAG]) begin
        next_flag = 1'b0;
      end
      if (reset_ev) begin
        next_flag = 1'b1; // [R6]
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st <= '{en: 1'b0, rst_en: 1'b0, win_en: 1'b0, timeout: WST_TC_RESET,
              window: WST_WINDOW_RESET, warn: WST_WARN_RESET, cnt: WST_TC_RESET,
              pre: 2'h0, armed: 1'b0, warned: 1'b0, status: 3'h0,
              mask: WST_MASK_RESET, irq: 1'b0, chip_rst: 1'b0, rdata: 32'h0};
    end else begin
      st <= next_st;
    end
  end

  // flag cleared only at power-on or by a write-one, so it outlives the chip reset
  always_ff @(posedge mclk or posedge power_on_reset) begin
    if (power_on_reset) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  assign rdata = st.rdata;
  assign chip_reset_req = st.chip_rst;
  assign irq = st.irq;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_timeout_reset;
    timeout_ev && st.rst_en |=> chip_reset_req && !st.en;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset) else $error("no reset on time-out"); // [R1]

  property p_window_fault;
    early |=> (chip_reset_req || st.status[WST_ST_FAULT]) && !st.en;
  endproperty
  a_window_fault: assert property (p_window_fault) else $error("early reload not faulted"); // [R2]

  property p_warn;
    warn_ev |=> st.status[WST_ST_WARN] && st.warned;
  endproperty
  a_warn: assert property (p_warn) else $error("warning not raised"); // [R3]

  property p_enable_sticky;
    st.en && !timeout_ev && !fault |=> st.en;
  endproperty
  a_enable_sticky: assert property (p_enable_sticky) else $error("enable dropped"); // [R4]

  property p_bad_feed;
    bad_feed && !st.rst_en |=> st.status[WST_ST_FAULT] && !chip_reset_req;
  endproperty
  a_bad_feed: assert property (p_bad_feed) else $error("bad feed not flagged"); // [R5]

  property p_flag;
    chip_reset_req |-> flag;
  endproperty
  a_flag: assert property (p_flag) else $error("reset flag missing"); // [R6]

  property p_count_step;
    pre_tick && st.cnt != '0 && !reload && !fault |=> st.cnt == $past(st.cnt) - 24'h000001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter step wrong"); // [R7]

  property p_count_hold;
    ce && !pre_tick && !reload && st.en && $stable(st.en) |=> $stable(st.cnt);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved off tick"); // [R7]

  property p_tick_pulse;
    tick |=> !tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick not a pulse"); // [R8]

  property p_reload;
    reload |=> st.cnt == $past(st.timeout) && !st.warned && st.pre == 2'h0;
  endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong"); // [R9]

  // enable, lock, fault, arming, status clear, flag, clamp, prescaler, clock-enable, reset pulse, window and warning checks
  property p_enable_set;
    wr_ok && addr == WST_OFF_MODE && wdata[WST_MODE_EN] && !st.en
      |=> st.en && st.cnt == $past(st.timeout) && st.pre == 2'h0;
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("enable did not load counter"); // [R4]

  property p_mode_lock;
    st.en |=> $stable(st.rst_en) && $stable(st.win_en);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("mode bits changed while enabled"); // [R4]

  property p_fault_reset;
    fault && st.rst_en |=> chip_reset_req && !st.en;
  endproperty
  a_fault_reset: assert property (p_fault_reset) else $error("fault gave no chip reset"); // [R5]

  property p_arm;
    good_first && !timeout_ev |=> st.armed;
  endproperty
  a_arm: assert property (p_arm) else $error("first feed word not armed"); // [R5]

  property p_w1c;
    wr_ok && addr == WST_OFF_STATUS
      |=> (st.status & $past(wdata[2:0]) & ~$past(ev)) == 3'h0;
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared"); // [R5]

  // flag must outlive the system reset, only power-on or a write-one clears it
  property p_flag_hold;
    disable iff (power_on_reset)
    flag && !(wr_ok && addr == WST_OFF_MODE && wdata[WST_MODE_FLAG]) |=> flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("reset flag lost"); // [R6]

  property p_clamp;
    wr_ok && addr == WST_OFF_TIMEOUT
      |=> st.timeout >= WST_TC_MIN
          && (st.timeout == $past(wdata[23:0]) || $past(wdata[23:0]) < WST_TC_MIN);
  endproperty
  a_clamp: assert property (p_clamp) else $error("time-out value not clamped"); // [R7]

  property p_prescale;
    tick && st.en && !reload |=> st.pre == $past(st.pre) + 2'h1;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler step wrong"); // [R7]

  property p_ce_freeze;
    !ce |=> $stable(st) && $stable(flag);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with ce low"); // [R7]

  property p_reset_pulse;
    chip_reset_req && ce |=> !chip_reset_req;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("chip reset not a pulse"); // [R1]

  property p_in_window;
    st.en && good_second && st.win_en && st.cnt <= st.window
      |=> st.en && st.cnt == $past(st.timeout);
  endproperty
  a_in_window: assert property (p_in_window) else $error("reload in window refused"); // [R2]

  property p_warn_irq;
    warn_ev && st.mask[WST_ST_WARN] && !(wr_ok && addr == WST_OFF_MASK) |=> irq;
  endproperty
  a_warn_irq: assert property (p_warn_irq) else $error("warning gave no interrupt"); // [R3]

  c_reload: cover property (reload);
  c_timeout: cover property (timeout_ev);
  c_bad_feed: cover property (bad_feed);
  c_warn: cover property (warn_ev);
  c_early: cover property (early);
endmodule

// ---- verif/wst_timer_tb.sv ----
// self-checking testbench of the windowed supervision timer
`timescale 1ns/100ps
module wst_timer_tb
  import wst_pkg::*;
;
  logic mclk;
  logic reset = 1'b1;
  logic power_on_reset = 1'b1;
  logic ce = 1'b1;
  logic supervision_tick_clock = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic chip_reset_req;
  logic irq;
  int err_count = 0;
  int cmp_count = 0;
  logic [31:0] v;
  logic [31:0] v2;
  int n;

  wst_timer DUT (
    .mclk(mclk), .reset(reset), .power_on_reset(power_on_reset), .ce(ce),
    .supervision_tick_clock(supervision_tick_clock), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .chip_reset_req(chip_reset_req), .irq(irq)
  );

  // 40 MHz bus clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // free-running tick clock, 4 bus cycles per tick, offset in phase
  initial begin
    #7;
    forever #50 supervision_tick_clock = ~supervision_tick_clock;
  end

  // count a comparison and report a mismatch
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  // one-cycle register write
  task wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // one-cycle register read, data taken in the following cycle
  task rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // bounded wait for irq (sel high) or chip reset request (sel low)
  task wait_ev(input logic sel, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge mclk);
      #1;
      cnt++;
    end while (cnt < lim && (sel ? irq : chip_reset_req) !== 1'b1);
  endtask

  // correct two-word reload
  task feed;
    wr_reg(WST_OFF_FEED, {24'h0, WST_FEED_FIRST});
    wr_reg(WST_OFF_FEED, {24'h0, WST_FEED_SECOND});
  endtask

  // pulse one of the two resets for two cycles
  task pulse(input logic por);
    @(posedge mclk);
    if (por) power_on_reset <= 1'b1;
    else reset <= 1'b1;
    repeat (2) @(posedge mclk);
    power_on_reset <= 1'b0;
    reset <= 1'b0;
  endtask

  // reset values, clamp of short time-out, unmapped read
  task t_reset;
    rd_reg(WST_OFF_TIMEOUT, v);
    chk(v === 32'h000000ff, "timeout reset value");
    rd_reg(WST_OFF_WINDOW, v);
    chk(v === 32'h00ffffff, "window reset value");
    rd_reg(WST_OFF_MODE, v);
    chk(v === 32'h00000000, "mode reset value");
    rd_reg(5'h02, v);
    chk(v === 32'h00000000, "unmapped read");
    wr_reg(WST_OFF_TIMEOUT, 32'h00000010);
    rd_reg(WST_OFF_TIMEOUT, v);
    chk(v === 32'h000000ff, "timeout clamp");
    $display("test reset done");
  endtask

  // run out with reset enabled, enable locked, flag survives reset
  task t_timeout;
    wr_reg(WST_OFF_MODE, 32'h00000003);
    wr_reg(WST_OFF_MODE, 32'h00000000);
    rd_reg(WST_OFF_MODE, v);
    chk(v[0] === 1'b1, "enable cleared by write");
    wait_ev(1'b0, 5000, n);
    chk(n > 3990 && n < 4200, "time-out period");
    rd_reg(WST_OFF_MODE, v);
    chk(v[0] === 1'b0 && v[3] === 1'b1, "flag or enable after time-out");
    pulse(1'b0);
    rd_reg(WST_OFF_MODE, v);
    chk(v[3] === 1'b1, "flag lost in reset");
    pulse(1'b1);
    rd_reg(WST_OFF_MODE, v);
    chk(v[3] === 1'b0, "flag kept through power-on");
    $display("test timeout done");
  endtask

  // reload restores count, wrong feed raises fault interrupt
  task t_feed;
    wr_reg(WST_OFF_MASK, 32'h00000004);
    wr_reg(WST_OFF_MODE, 32'h00000001);
    repeat (200) @(posedge mclk);
    rd_reg(WST_OFF_VALUE, v);
    chk(v < 32'h000000f8, "counter not running");
    @(posedge mclk);
    ce <= 1'b0;
    repeat (40) @(posedge mclk);
    ce <= 1'b1;
    rd_reg(WST_OFF_VALUE, v2);
    chk(v2 <= v && v2 + 32'h00000001 >= v, "counter ran with ce low");
    feed();
    rd_reg(WST_OFF_VALUE, v);
    chk(v >= 32'h000000fe && v <= 32'h000000ff, "reload value");
    wr_reg(WST_OFF_FEED, 32'h00000012);
    wait_ev(1'b1, 10, n);
    chk(n < 10 && chip_reset_req === 1'b0, "bad feed irq");
    rd_reg(WST_OFF_STATUS, v);
    chk(v === 32'h00000004, "fault status");
    rd_reg(WST_OFF_MODE, v);
    chk(v[0] === 1'b0, "enable after interrupt event");
    wr_reg(WST_OFF_STATUS, 32'h00000004);
    repeat (2) @(posedge mclk);
    #1;
    chk(irq === 1'b0, "irq after clear");
    $display("test feed done");
  endtask

  // warning point, reload inside the window, then one before it opens
  task t_window;
    wr_reg(WST_OFF_WINDOW, 32'h000000f8);
    wr_reg(WST_OFF_WARN, 32'h000000f0);
    rd_reg(WST_OFF_WARN, v);
    chk(v === 32'h000000f0, "warning value readback");
    wr_reg(WST_OFF_MASK, 32'h00000002);
    wr_reg(WST_OFF_MODE, 32'h00000005);
    wait_ev(1'b1, 400, n);
    chk(n > 200 && n < 330, "warning time");
    rd_reg(WST_OFF_STATUS, v);
    chk(v === 32'h00000002, "warning status");
    wr_reg(WST_OFF_STATUS, 32'h00000002);
    wr_reg(WST_OFF_MASK, 32'h00000004);
    feed();
    rd_reg(WST_OFF_VALUE, v);
    chk(v >= 32'h000000fe && v <= 32'h000000ff, "in-window reload value");
    rd_reg(WST_OFF_STATUS, v);
    chk(v === 32'h00000000, "in-window reload faulted");
    feed();
    wait_ev(1'b1, 10, n);
    chk(n < 10, "early reload not faulted");
    rd_reg(WST_OFF_STATUS, v);
    chk(v[2] === 1'b1, "window fault status");
    $display("test window done");
  endtask

  // wrong feed with reset enabled, then flag cleared by write-one
  task t_fault_reset;
    wr_reg(WST_OFF_MODE, 32'h00000003);
    wr_reg(WST_OFF_FEED, {24'h0, WST_FEED_SECOND});
    #1;
    chk(chip_reset_req === 1'b1, "bad feed gave no chip reset");
    rd_reg(WST_OFF_MODE, v);
    chk(v === 32'h0000000a, "mode after fault reset");
    wr_reg(WST_OFF_MODE, 32'h00000008);
    rd_reg(WST_OFF_MODE, v);
    chk(v === 32'h00000000, "flag not cleared by write");
    $display("test fault reset done");
  endtask

  // counts and verdict
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    power_on_reset <= 1'b0;
    t_reset();
    t_timeout();
    t_feed();
    t_window();
    t_fault_reset();
    summarize();
  end

  // hang guard, about twice the expected run
  initial begin
    #(25 * 10000);
    err_count++;
    summarize();
  end
endmodule
